// >>> shared/mipend_pkg.sv
// Constants for the pending interrupt status block
package mipend_pkg;
	localparam logic [7:0] MIPEND_STAT_ADDR = 8'h14;
	localparam logic [7:0] MIPEND_STAT_RST = 8'h00;
	localparam int MIPEND_TILT = 0;
	localparam int MIPEND_FLIP = 1;
	localparam int MIPEND_ANYM = 2;
	localparam int MIPEND_SHAKE = 3;
	localparam int MIPEND_T35 = 4;
	localparam int MIPEND_QUEUE = 5;
	localparam int MIPEND_RESV = 6;
	localparam int MIPEND_ACQ = 7;
	localparam int MIPEND_MC_TILTFLIP = 0;
	localparam int MIPEND_MC_ANYM = 2;
	localparam int MIPEND_MC_SHAKE = 3;
	localparam int MIPEND_MC_T35 = 4;
	localparam int MIPEND_NBITS = 8;
endpackage

// >>> core/mipend_latch.sv
// One sticky pending bit with set-over-clear priority
`timescale 1ns/100ps
module mipend_latch (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic set_i, // Qualified event
	input wire logic clr_i, // Host clear request
	output logic pend_o // Pending level
);
	logic pend_q;
	logic pend_d;
	// Set wins so an event in the clear cycle survives
	assign pend_d = set_i | (pend_q & ~clr_i); // [RULE12]
	always_ff @(posedge clock) begin
		if (srst) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
		end
	end
	assign pend_o = pend_q;
endmodule // mipend_latch

// >>> core/mipend_top.sv
// Pending interrupt status byte for the motion sensor
// Behaviour
// [RULE1] A pending bit sets only when its interrupt enable bit is set.
// [RULE2] Default: any status write clears all pending bits regardless of data.
// [RULE3] With per-bit clear selected, a write clears only bits set in data.
// [RULE4] Status at 0x14, reset 0x00; tilt,flip,anym,shake,t35,queue,resv,acq.
// [RULE5] Tilt pends on event with enable bit 0 and tilt/flip feature on.
// [RULE6] Flip pends on event with enable bit 1 and tilt/flip feature on.
// [RULE7] Any-motion pends with enable bit 2 and any-motion feature on.
// [RULE8] Shake needs enable bit 3, feature bit 3 and any-motion feature.
// [RULE9] Tilt-35 needs enable bit 4, feature bit 4 and any-motion feature.
// [RULE10] Queue pending is OR of full, level and empty queue flags.
// [RULE11] Sample-acquired pends only in wake state with enable bit 7.
// [RULE12] Pending bits stay set until host clears; bit 6 reads zero.
`timescale 1ns/100ps
module mipend_top
	import mipend_pkg::*;
(
	input wire logic clock, // System clock, 100 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [7:0] int_enable, // Interrupt enable register
	input wire logic [7:0] motion_ctrl, // Motion control register
	input wire logic per_bit_clear_select, // Bitmask clear mode
	input wire logic wake_state, // Device in wake state
	input wire logic tilt_evt, // Tilt event pulse
	input wire logic flip_evt, // Flip event pulse
	input wire logic anym_evt, // Any-motion event pulse
	input wire logic shake_evt, // Shake event pulse
	input wire logic t35_evt, // Tilt-35 event pulse
	input wire logic acq_evt, // Sample acquired pulse
	input wire logic queue_full_flag, // Queue full flag
	input wire logic queue_level_flag, // Queue threshold flag
	input wire logic queue_empty_flag, // Queue empty flag
	input wire logic reg_wr, // Register write strobe
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] pending_interrupt_flags // Status byte
);
	logic [7:0] set_w;
	logic [7:0] clr_w;
	logic [7:0] pend_w;
	logic [7:0] stat_q;
	logic stat_wr;
	logic tf_on;
	logic am_on;

	assign stat_wr = reg_wr & (reg_addr == MIPEND_STAT_ADDR); // [RULE4]
	assign tf_on = motion_ctrl[MIPEND_MC_TILTFLIP];
	assign am_on = motion_ctrl[MIPEND_MC_ANYM];

	assign set_w[MIPEND_TILT] = tilt_evt & int_enable[MIPEND_TILT]
		& tf_on; // [RULE1] [RULE5]
	assign set_w[MIPEND_FLIP] = flip_evt & int_enable[MIPEND_FLIP]
		& tf_on; // [RULE6]
	assign set_w[MIPEND_ANYM] = anym_evt & int_enable[MIPEND_ANYM]
		& am_on; // [RULE7]
	assign set_w[MIPEND_SHAKE] = shake_evt & int_enable[MIPEND_SHAKE]
		& motion_ctrl[MIPEND_MC_SHAKE] & am_on; // [RULE8]
	assign set_w[MIPEND_T35] = t35_evt & int_enable[MIPEND_T35]
		& motion_ctrl[MIPEND_MC_T35] & am_on; // [RULE9]
	// Queue flags already latch upstream; gated by its enable too
	assign set_w[MIPEND_QUEUE] = (queue_full_flag | queue_level_flag
		| queue_empty_flag) & int_enable[MIPEND_QUEUE]; // [RULE10]
	assign set_w[MIPEND_RESV] = 1'b0; // [RULE12]
	assign set_w[MIPEND_ACQ] = acq_evt & int_enable[MIPEND_ACQ]
		& wake_state; // [RULE11]

	// Write data is a don't-care unless per-bit clear is selected
	assign clr_w = per_bit_clear_select ? ({8{stat_wr}} & reg_wdata)
		: {8{stat_wr}}; // [RULE2] [RULE3]

	genvar gi;
	generate
		for (gi = 0; gi < MIPEND_NBITS; gi++) begin : g_bit
			mipend_latch u_latch (
				.clock(clock),
				.srst(srst),
				.set_i(set_w[gi]),
				.clr_i(clr_w[gi]),
				.pend_o(pend_w[gi])
			);
		end
	endgenerate

	// Output register keeps the port straight from a flop
	always_ff @(posedge clock) begin
		if (srst) begin
			stat_q <= MIPEND_STAT_RST; // [RULE4]
		end else begin
			stat_q <= pend_w;
		end
	end
	assign pending_interrupt_flags = stat_q;

	tilt_gate_a: assert property (@(posedge clock) disable iff (srst)
		(tilt_evt && !tf_on && !pend_w[MIPEND_TILT])
		|=> !pend_w[MIPEND_TILT]) // [RULE5]
		else $error("tilt pended without feature enable");
	enable_gate_a: assert property (@(posedge clock) disable iff (srst)
		(!int_enable[MIPEND_FLIP] && !pend_w[MIPEND_FLIP])
		|=> !pend_w[MIPEND_FLIP]) // [RULE1]
		else $error("flip pended while disabled");
	clear_all_a: assert property (@(posedge clock) disable iff (srst)
		(stat_wr && !per_bit_clear_select && set_w == 8'h00)
		|=> pend_w == 8'h00 ##1 stat_q == 8'h00) // [RULE2]
		else $error("write did not clear all");
	mask_clear_a: assert property (@(posedge clock) disable iff (srst)
		(stat_wr && per_bit_clear_select && !reg_wdata[MIPEND_ANYM])
		|=> pend_w[MIPEND_ANYM] == $past(pend_w[MIPEND_ANYM])
		|| pend_w[MIPEND_ANYM]) // [RULE3]
		else $error("unmasked bit cleared");
	shake_gate_a: assert property (@(posedge clock) disable iff (srst)
		(shake_evt && int_enable[MIPEND_SHAKE]
		&& motion_ctrl[MIPEND_MC_SHAKE] && am_on)
		|=> ##1 stat_q[MIPEND_SHAKE]) // [RULE8]
		else $error("shake not reported");
	resv_zero_a: assert property (@(posedge clock)
		disable iff (srst) !stat_q[MIPEND_RESV]) // [RULE12]
		else $error("reserved bit set");
	sticky_hold_a: assert property (@(posedge clock) disable iff (srst)
		(pend_w[MIPEND_T35] && !stat_wr) |=> pend_w[MIPEND_T35]) // [RULE12]
		else $error("pending bit dropped");
	acq_wake_a: assert property (@(posedge clock) disable iff (srst)
		(!wake_state && !pend_w[MIPEND_ACQ]) |=> !pend_w[MIPEND_ACQ]) // [RULE11]
		else $error("acquire pended outside wake");
	queue_or_a: assert property (@(posedge clock) disable iff (srst)
		(queue_empty_flag && int_enable[MIPEND_QUEUE])
		|=> ##1 stat_q[MIPEND_QUEUE]) // [RULE10]
		else $error("queue pending missing");

	tilt_set_a: assert property (@(posedge clock) disable iff (srst)
		(tilt_evt && int_enable[MIPEND_TILT] && tf_on)
		|=> pend_w[MIPEND_TILT]) // [RULE5]
		else $error("tilt event lost");

	flip_set_a: assert property (@(posedge clock) disable iff (srst)
		(flip_evt && int_enable[MIPEND_FLIP] && tf_on)
		|=> pend_w[MIPEND_FLIP]) // [RULE6]
		else $error("flip event lost");

	flip_gate_a: assert property (@(posedge clock) disable iff (srst)
		(!tf_on && !pend_w[MIPEND_FLIP])
		|=> !pend_w[MIPEND_FLIP]) // [RULE6]
		else $error("flip pended without feature enable");

	anym_set_a: assert property (@(posedge clock) disable iff (srst)
		(anym_evt && int_enable[MIPEND_ANYM] && am_on)
		|=> pend_w[MIPEND_ANYM]) // [RULE7]
		else $error("any-motion event lost");

	anym_gate_a: assert property (@(posedge clock) disable iff (srst)
		(!am_on && !pend_w[MIPEND_ANYM])
		|=> !pend_w[MIPEND_ANYM]) // [RULE7]
		else $error("any-motion pended without feature");

	shake_need_a: assert property (@(posedge clock) disable iff (srst)
		(!am_on && !pend_w[MIPEND_SHAKE])
		|=> !pend_w[MIPEND_SHAKE]) // [RULE8]
		else $error("shake pended without any-motion");

	t35_set_a: assert property (@(posedge clock) disable iff (srst)
		(t35_evt && int_enable[MIPEND_T35]
		&& motion_ctrl[MIPEND_MC_T35] && am_on)
		|=> pend_w[MIPEND_T35]) // [RULE9]
		else $error("tilt-35 event lost");

	t35_gate_a: assert property (@(posedge clock) disable iff (srst)
		(!am_on && !pend_w[MIPEND_T35])
		|=> !pend_w[MIPEND_T35]) // [RULE9]
		else $error("tilt-35 pended without any-motion");

	queue_full_a: assert property (@(posedge clock) disable iff (srst)
		(queue_full_flag && int_enable[MIPEND_QUEUE])
		|=> pend_w[MIPEND_QUEUE]) // [RULE10]
		else $error("queue full not pended");

	queue_level_a: assert property (@(posedge clock) disable iff (srst)
		(queue_level_flag && int_enable[MIPEND_QUEUE])
		|=> pend_w[MIPEND_QUEUE]) // [RULE10]
		else $error("queue level not pended");

	queue_quiet_a: assert property (@(posedge clock) disable iff (srst)
		(!queue_full_flag && !queue_level_flag && !queue_empty_flag
		&& !pend_w[MIPEND_QUEUE]) |=> !pend_w[MIPEND_QUEUE]) // [RULE10]
		else $error("queue pended with no flag");

	acq_set_a: assert property (@(posedge clock) disable iff (srst)
		(acq_evt && int_enable[MIPEND_ACQ] && wake_state)
		|=> pend_w[MIPEND_ACQ]) // [RULE11]
		else $error("acquire event lost");

	acq_enable_a: assert property (@(posedge clock) disable iff (srst)
		(!int_enable[MIPEND_ACQ] && !pend_w[MIPEND_ACQ])
		|=> !pend_w[MIPEND_ACQ]) // [RULE11]
		else $error("acquire pended while disabled");

	// Set must beat a clear landing in the same cycle
	set_wins_a: assert property (@(posedge clock) disable iff (srst)
		(set_w[MIPEND_TILT] && stat_wr)
		|=> pend_w[MIPEND_TILT]) // [RULE12]
		else $error("event lost to clear");

	out_follow_a: assert property (@(posedge clock) disable iff (srst)
		1'b1 |=> stat_q == $past(pend_w)) // [RULE4]
		else $error("status byte not one cycle behind");

	other_addr_a: assert property (@(posedge clock) disable iff (srst)
		(reg_wr && !stat_wr && set_w == 8'h00)
		|=> pend_w == $past(pend_w)) // [RULE4]
		else $error("write to other address changed status");

	mask_keep_a: assert property (@(posedge clock) disable iff (srst)
		(stat_wr && per_bit_clear_select && set_w == 8'h00)
		|=> pend_w == ($past(pend_w) & ~$past(reg_wdata))) // [RULE3]
		else $error("bitmask clear wrong");

	// Checked without disable so the reset edge itself is seen
	reset_value_a: assert property (@(posedge clock)
		srst |=> stat_q == MIPEND_STAT_RST) // [RULE4]
		else $error("status byte not reset");
endmodule // mipend_top

// >>> verif/mipend_host.sv
// Host processor model issuing status byte writes
`timescale 1ns/100ps
module mipend_host (
	input wire logic clock, // System clock
	output logic reg_wr = 1'b0, // Write strobe
	output logic [7:0] reg_addr = 8'h00, // Register address
	output logic [7:0] reg_wdata = 8'h00 // Write data
);
	// Lines invert after the strobe so stale values never match
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule // mipend_host

// >>> verif/motion_interrupt_status_bench.sv
// Self-checking bench for the pending interrupt status block
`timescale 1ns/100ps
module motion_interrupt_status_bench;
	import mipend_pkg::*;
	typedef struct packed {
		logic [7:0] ien;
		logic [7:0] mc;
		logic wake;
		logic [5:0] ev;
		logic [2:0] q;
		logic [7:0] exp;
	} mipend_row_t;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] ien = 8'h00;
	logic [7:0] mc = 8'h00;
	logic pbc = 1'b0;
	logic wake = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [2:0] q = 3'h0;
	logic reg_wr;
	logic [7:0] reg_addr, reg_wdata, flags;
	int n_fail = 0;
	int check_count = 0;
	mipend_row_t rows [7] = '{
		'{8'hFF, 8'h1D, 1'b1, 6'h3F, 3'h1, 8'hBF},
		'{8'h00, 8'h1D, 1'b1, 6'h3F, 3'h7, 8'h00},
		'{8'hFF, 8'h00, 1'b1, 6'h3F, 3'h0, 8'h80},
		'{8'hFF, 8'h1B, 1'b0, 6'h3F, 3'h0, 8'h03},
		'{8'h7F, 8'h1D, 1'b1, 6'h3F, 3'h2, 8'h3F},
		'{8'h01, 8'h01, 1'b1, 6'h02, 3'h4, 8'h00},
		'{8'h20, 8'h00, 1'b0, 6'h00, 3'h4, 8'h20}};
	always #5 clock = ~clock;
	mipend_host mipend_host_inst (.clock(clock), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	mipend_top mipend_top_inst (.clock(clock), .srst(srst),
		.int_enable(ien), .motion_ctrl(mc), .per_bit_clear_select(pbc),
		.wake_state(wake), .tilt_evt(ev[0]), .flip_evt(ev[1]),
		.anym_evt(ev[2]), .shake_evt(ev[3]), .t35_evt(ev[4]),
		.acq_evt(ev[5]), .queue_full_flag(q[0]), .queue_level_flag(q[1]),
		.queue_empty_flag(q[2]), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .pending_interrupt_flags(flags));
	task automatic check(input string nm, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Two edges of latency, so sample on the third falling edge
	task automatic fire(input mipend_row_t r);
		@(negedge clock);
		{ien, mc, wake, ev, q} = {r.ien, r.mc, r.wake, r.ev, r.q};
		@(negedge clock);
		{ev, q} = 9'h000;
		repeat (2) @(negedge clock);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clock);
		check("reset", flags, MIPEND_STAT_RST);
		srst = 1'b0;
		foreach (rows[i]) begin
			mipend_host_inst.write(MIPEND_STAT_ADDR, 8'h00);
			fire(rows[i]);
			check("row", flags, rows[i].exp);
			// Same rows also
		end
		mipend_host_inst.write(MIPEND_STAT_ADDR, 8'h00);
		fire(mipend_row_t'{8'hFF, 8'h1D, 1'b0, 6'h1F, 3'h0, 8'h1F});
		repeat (6) @(negedge clock);
		check("held", flags, 8'h1F);
		mipend_host_inst.write(8'h15, 8'hFF);
		repeat (2) @(negedge clock);
		check("other addr", flags, 8'h1F);
		pbc = 1'b1;
		mipend_host_inst.write(MIPEND_STAT_ADDR, 8'h05);
		repeat (2) @(negedge clock);
		check("mask clear", flags, 8'h1A);
		pbc = 1'b0;
		mipend_host_inst.write(MIPEND_STAT_ADDR, 8'h5A);
		repeat (2) @(negedge clock);
		check("clear all", flags, 8'h00);
		// Event and clear in one cycle: the event must survive
		fork
			mipend_host_inst.write(MIPEND_STAT_ADDR, 8'h00);
			begin
				@(negedge clock);
				ev = 6'h01;
				@(negedge clock);
				ev = 6'h00;
			end
		join
		repeat (2) @(negedge clock);
		check("set wins", flags, 8'h01);
		@(negedge clock);
		srst = 1'b1;
		@(negedge clock);
		check("mid reset", flags, MIPEND_STAT_RST);
		srst = 1'b0;
		fire(rows[0]);
		check("after reset", flags, rows[0].exp);
		give_verdict();
	end
endmodule // motion_interrupt_status_bench
